// file: hdl/drive_cfg.svh
// Purpose: addresses, field positions, reset values of the profile parameter block
// Assumes: parameter addresses are the fieldbus word addresses, 16 bits wide
// Notes:   definitions only
`ifndef DRIVE_CFG_SVH
`define DRIVE_CFG_SVH

`define ADR_HOME_REQ    16'h062c
`define ADR_TGT_POS     16'h1b1c
`define ADR_TRV_SPD     16'h1b1e
`define ADR_REL_OPT     16'h1b30
`define ADR_ACT_POS     16'h1e1a
`define ADR_GEN_POS     16'h1f04
`define ADR_VEL_SET     16'h1b1a

`define RST_HOME_REQ    16'h0000
`define RST_TGT_POS     32'h00000000
`define RST_TRV_SPD     32'h0000003c
`define RST_REL_OPT     16'h0000
`define RST_POS         32'h00000000
`define RST_VEL_SET     32'h00000000

`define TRV_SPD_MIN     32'h00000001
`define REL_OPT_PREV    16'h0000
`define REL_OPT_BAD     16'h0001
`define REL_OPT_ACT     16'h0002

`define ST_REACHED      10
`define ST_SPEED0       12
`define ST_ERROR        13
`define ST_END          14
`define ST_REF_OK       15

`define RAMP_STEP_MIN   16'h0001

`endif

// file: hdl/drive_pkg.sv
// Purpose: shared types of the profile parameter block
// Assumes: drive_cfg.svh carries the numbers
// Notes:   one-hot velocity states
package drive_pkg;

    typedef enum logic [3:0] {
        VS_IDLE = 4'b0001,
        VS_RUN  = 4'b0010,
        VS_STOP = 4'b0100,
        VS_DONE = 4'b1000
    } vel_state_t;

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_HOME,
        SEL_TPOS,
        SEL_TSPD,
        SEL_OPT,
        SEL_APOS,
        SEL_GPOS,
        SEL_VSET
    } reg_sel_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [31:0] wdata;
    } par_req_t;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [31:0] rdata;
    } par_rsp_t;

endpackage

// file: hdl/speed_ramp.sv
// Purpose: speed generator that walks toward a target by accel / decel steps
// Assumes: steps are per enabled clock; a zero step counts as the least step
// Notes:   speed moving away from zero uses the accel step, toward zero the decel step
`timescale 1ns/1ps
`default_nettype none
`include "drive_cfg.svh"
module speed_ramp
    import drive_pkg::*;
(
    input  wire logic               clk_i,      // system clock
    input  wire logic               nrst_i,     // async reset, low
    input  wire logic               ce_i,       // clock enable
    input  wire logic signed [31:0] target_i,   // wanted speed
    input  wire logic        [15:0] acc_step_i, // accel step
    input  wire logic        [15:0] dec_step_i, // decel step
    output logic signed      [31:0] speed_o     // generator speed
);
    logic signed [31:0] next_speed;
    logic signed [32:0] sum;
    logic signed [32:0] tgt33;
    logic        [15:0] stp;
    logic               up;
    logic               accel;

    always_comb begin
        up    = target_i > speed_o;
        accel = up ? (speed_o >= 0) : (speed_o <= 0);
        stp   = accel ? acc_step_i : dec_step_i;
        if (stp == 16'h0000) begin
            stp = `RAMP_STEP_MIN;
        end
        tgt33 = {target_i[31], target_i};
        sum   = up ? ({speed_o[31], speed_o} + $signed({17'h00000, stp}))
                   : ({speed_o[31], speed_o} - $signed({17'h00000, stp}));
        if (speed_o == target_i) begin
            next_speed = speed_o;
        end else if (up ? (sum >= tgt33) : (sum <= tgt33)) begin
            next_speed = target_i;
        end else begin
            next_speed = sum[31:0];
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            speed_o <= 32'sh00000000;
        end else if (ce_i) begin
            speed_o <= next_speed;
        end
    end

    ramp_moves_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ce_i && (speed_o != target_i) |=> (speed_o != $past(speed_o)))
        else $error("ramp did not step toward its target");

endmodule
`default_nettype wire

// file: hdl/profile_param_top.sv
// Purpose: profile position parameters and profile velocity control with status word
// Assumes: parameter port is the fieldbus word access, synchronous to clk_i
// Notes:   answer one cycle after a taken access; refused writes leave the value
`timescale 1ns/1ps
`default_nettype none
`include "drive_cfg.svh"
module profile_param_top
    import drive_pkg::*;
(
    input  wire logic        clk_i,               // system clock, 100 MHz
    input  wire logic        nrst_i,              // async reset, low
    input  wire logic        ce_i,                // clock enable, freezes all state
    input  wire par_req_t    par_req_i,           // parameter access request
    output par_rsp_t         par_rsp_o,           // parameter access answer
    input  wire logic        mode_velocity_i,     // velocity mode selected
    input  wire logic        op_enabled_i,        // drive in operation enabled
    input  wire logic        halt_i,              // halt request
    input  wire logic        fault_i,             // drive error present
    input  wire logic        homed_i,             // valid reference point
    input  wire logic        nv_home_i,           // stored homing setting
    input  wire logic [31:0] maximum_speed_limit_i, // speed limit, rpm
    input  wire logic [15:0] acc_step_i,          // accel step per cycle
    input  wire logic [15:0] dec_step_i,          // decel step per cycle
    input  wire logic [31:0] actual_position_i,   // motor position, usr
    input  wire logic [31:0] generator_position_i, // generator position, usr
    output logic [31:0]      target_position_o,   // position goal
    output logic [31:0]      position_speed_o,    // clamped travel speed
    output logic             relative_base_o,     // 1: actual position base
    output logic             abs_allowed_o,       // absolute move permitted
    output logic             nv_home_wr_o,        // store homing setting, pulse
    output logic             nv_home_o,           // value to store
    output logic [31:0]      velocity_speed_o,    // generator speed
    output logic [15:0]      drive_status_word_o  // status word
);
    // parameter group
    logic [15:0] absolute_needs_homing;
    logic [31:0] position_travel_speed;
    logic [15:0] relative_base_option;
    logic [31:0] velocity_setpoint;
    logic [31:0] actual_position;
    logic [31:0] generator_position;
    logic        nv_loaded;
    logic [15:0] next_home;
    logic [31:0] next_tpos;
    logic [31:0] next_tspd;
    logic [15:0] next_opt;
    logic [31:0] next_vset;
    logic        next_loaded;
    logic        next_nv_wr;
    par_rsp_t    next_rsp;
    reg_sel_t    sel;
    logic        vset_wr;

    // velocity group
    vel_state_t         vstate;
    vel_state_t         next_vstate;
    logic [15:0]        next_status;
    logic [31:0]        next_pspd;
    logic               next_abs_ok;
    logic signed [31:0] ramp_tgt;
    logic signed [31:0] speed;
    logic signed [31:0] vset_clamped;
    logic signed [31:0] new_clamped;

    function automatic reg_sel_t decode(input logic [15:0] a);
        case (a)
            `ADR_HOME_REQ: decode = SEL_HOME;
            `ADR_TGT_POS:  decode = SEL_TPOS;
            `ADR_TRV_SPD:  decode = SEL_TSPD;
            `ADR_REL_OPT:  decode = SEL_OPT;
            `ADR_ACT_POS:  decode = SEL_APOS;
            `ADR_GEN_POS:  decode = SEL_GPOS;
            `ADR_VEL_SET:  decode = SEL_VSET;
            default:       decode = SEL_NONE;
        endcase
    endfunction

    // symmetric clamp of a signed speed to the unsigned limit
    function automatic logic signed [31:0] clamp_speed(input logic signed [31:0] v,
                                                      input logic [31:0] lim);
        logic [31:0] mag;
        logic [31:0] cap;
        mag = v[31] ? (~v + 32'h00000001) : v;
        cap = (lim[31]) ? 32'h7fffffff : lim;
        if (mag > cap) begin
            clamp_speed = v[31] ? (~cap + 32'h00000001) : cap;
        end else begin
            clamp_speed = v;
        end
    endfunction

    assign sel     = decode(par_req_i.addr);
    assign vset_wr = par_req_i.wr && (sel == SEL_VSET);
    assign speed   = velocity_speed_o;

    always_comb begin
        next_home   = absolute_needs_homing;
        next_tpos   = target_position_o;
        next_tspd   = position_travel_speed;
        next_opt    = relative_base_option;
        next_vset   = velocity_setpoint;
        next_loaded = 1'b1;
        next_nv_wr  = 1'b0;
        next_rsp    = '{ack: 1'b0, err: 1'b0, rdata: 32'h00000000};
        // persistent setting restored once after reset release
        if (!nv_loaded) begin
            next_home = {15'h0000, nv_home_i};
        end
        if (par_req_i.wr) begin
            next_rsp.ack = 1'b1;
            case (sel)
                SEL_HOME: begin
                    if (par_req_i.wdata[31:1] == 31'h00000000) begin
                        next_home  = par_req_i.wdata[15:0];
                        next_nv_wr = 1'b1;
                    end else begin
                        next_rsp.err = 1'b1;
                    end
                end
                SEL_TPOS: next_tpos = par_req_i.wdata;
                SEL_TSPD: begin
                    if (par_req_i.wdata >= `TRV_SPD_MIN) begin
                        next_tspd = par_req_i.wdata;
                    end else begin
                        next_rsp.err = 1'b1;
                    end
                end
                SEL_OPT: begin
                    if (par_req_i.wdata == {16'h0000, `REL_OPT_PREV} ||
                        par_req_i.wdata == {16'h0000, `REL_OPT_ACT}) begin
                        next_opt = par_req_i.wdata[15:0];
                    end else begin
                        next_rsp.err = 1'b1;
                    end
                end
                SEL_VSET: next_vset = par_req_i.wdata;
                default:  next_rsp.err = 1'b1; // read-only or unmapped
            endcase
        end else if (par_req_i.rd) begin
            next_rsp.ack = 1'b1;
            case (sel)
                SEL_HOME: next_rsp.rdata = {16'h0000, absolute_needs_homing};
                SEL_TPOS: next_rsp.rdata = target_position_o;
                SEL_TSPD: next_rsp.rdata = position_travel_speed;
                SEL_OPT:  next_rsp.rdata = {16'h0000, relative_base_option};
                SEL_APOS: next_rsp.rdata = actual_position;
                SEL_GPOS: next_rsp.rdata = generator_position;
                SEL_VSET: next_rsp.rdata = velocity_setpoint;
                default:  next_rsp.err = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            absolute_needs_homing <= `RST_HOME_REQ;
            target_position_o     <= `RST_TGT_POS;
            position_travel_speed <= `RST_TRV_SPD;
            relative_base_option  <= `RST_REL_OPT;
            velocity_setpoint     <= `RST_VEL_SET;
            actual_position       <= `RST_POS;
            generator_position    <= `RST_POS;
            nv_loaded             <= 1'b0;
            nv_home_wr_o          <= 1'b0;
            nv_home_o             <= 1'b0;
            par_rsp_o             <= '0;
        end else if (ce_i) begin
            absolute_needs_homing <= next_home;
            target_position_o     <= next_tpos;
            position_travel_speed <= next_tspd;
            relative_base_option  <= next_opt;
            velocity_setpoint     <= next_vset;
            actual_position       <= actual_position_i;
            generator_position    <= generator_position_i;
            nv_loaded             <= next_loaded;
            nv_home_wr_o          <= next_nv_wr;
            nv_home_o             <= next_home[0];
            par_rsp_o             <= next_rsp;
        end
    end

    // velocity mode control
    always_comb begin
        vset_clamped = clamp_speed(velocity_setpoint, maximum_speed_limit_i);
        new_clamped  = clamp_speed(par_req_i.wdata, maximum_speed_limit_i);
        ramp_tgt     = (vstate == VS_RUN) ? vset_clamped : 32'sh00000000;
        next_vstate  = vstate;
        case (vstate)
            VS_IDLE, VS_DONE: begin
                if (vset_wr && mode_velocity_i && op_enabled_i && !fault_i && !halt_i &&
                    par_req_i.wdata != 32'h00000000) begin
                    next_vstate = VS_RUN;
                end
            end
            VS_RUN: begin
                if (halt_i || fault_i || !mode_velocity_i || !op_enabled_i ||
                    velocity_setpoint == 32'h00000000) begin
                    next_vstate = VS_STOP;
                end
            end
            VS_STOP: begin
                if (speed == 32'sh00000000) begin
                    next_vstate = VS_DONE;
                end
            end
            default: next_vstate = VS_IDLE;
        endcase
        next_status = 16'h0000;
        if (vset_wr && vstate == VS_RUN) begin
            next_status[`ST_REACHED] = (new_clamped == speed);
        end else begin
            next_status[`ST_REACHED] = ((vstate == VS_RUN) && (speed == ramp_tgt)) ||
                                       (halt_i && (speed == 32'sh00000000) &&
                                        (vstate != VS_IDLE));
        end
        next_status[`ST_SPEED0] = (speed == 32'sh00000000);
        next_status[`ST_ERROR]  = fault_i;
        next_status[`ST_END]    = (vstate == VS_DONE);
        next_status[`ST_REF_OK] = homed_i;
        next_pspd = (position_travel_speed > maximum_speed_limit_i) ?
                    maximum_speed_limit_i : position_travel_speed;
        next_abs_ok = !absolute_needs_homing[0] || homed_i;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            vstate              <= VS_IDLE;
            drive_status_word_o <= 16'h0000;
            position_speed_o    <= 32'h00000000;
            abs_allowed_o       <= 1'b1;
            relative_base_o     <= 1'b0;
        end else if (ce_i) begin
            vstate              <= next_vstate;
            drive_status_word_o <= next_status;
            position_speed_o    <= next_pspd;
            abs_allowed_o       <= next_abs_ok;
            relative_base_o     <= (relative_base_option == `REL_OPT_ACT);
        end
    end

    speed_ramp u_ramp (
        .clk_i      (clk_i),
        .nrst_i     (nrst_i),
        .ce_i       (ce_i),
        .target_i   (ramp_tgt),
        .acc_step_i (acc_step_i),
        .dec_step_i (dec_step_i),
        .speed_o    (velocity_speed_o)
    );

    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_vel_start;
        ce_i && vset_wr && mode_velocity_i && op_enabled_i && !fault_i && !halt_i &&
        (par_req_i.wdata != 32'h00000000) && (vstate inside {VS_IDLE, VS_DONE});
    endsequence

    sequence s_stop_done;
        ce_i && (vstate == VS_STOP) && (speed == 32'sh00000000);
    endsequence

    tpos_write_a: assert property (ce_i && par_req_i.wr && sel == SEL_TPOS |=>
        target_position_o == $past(par_req_i.wdata) && par_rsp_o.ack && !par_rsp_o.err)
        else $error("target position write not taken");
    opt_refused_a: assert property (ce_i && par_req_i.wr && sel == SEL_OPT &&
        par_req_i.wdata == 32'h00000001 |=> par_rsp_o.err &&
        relative_base_option == $past(relative_base_option))
        else $error("unsupported relative option accepted");
    speed_clamp_a: assert property (ce_i |=>
        position_speed_o <= $past(maximum_speed_limit_i))
        else $error("travel speed above limit");
    abs_gate_a: assert property (ce_i && absolute_needs_homing[0] && !homed_i |=>
        !abs_allowed_o)
        else $error("absolute move allowed without homing");
    act_pos_read_a: assert property (ce_i && $past(ce_i) && $past(nrst_i) &&
        par_req_i.rd && !par_req_i.wr && sel == SEL_APOS |=>
        par_rsp_o.rdata == $past(actual_position_i, 2))
        else $error("actual position read wrong");
    gen_pos_read_a: assert property (ce_i && $past(ce_i) && $past(nrst_i) &&
        par_req_i.rd && !par_req_i.wr && sel == SEL_GPOS |=>
        par_rsp_o.rdata == $past(generator_position_i, 2))
        else $error("generator position read wrong");
    vel_start_a: assert property (s_vel_start |=> vstate == VS_RUN)
        else $error("setpoint write did not start velocity mode");
    reached_bit_a: assert property (ce_i && vstate == VS_RUN && !vset_wr &&
        speed == ramp_tgt |=> drive_status_word_o[`ST_REACHED])
        else $error("reached bit missing");
    standstill_bit_a: assert property (ce_i |=>
        drive_status_word_o[`ST_SPEED0] == ($past(speed) == 32'sh00000000))
        else $error("standstill bit wrong");
    halt_stop_a: assert property (ce_i && vstate == VS_RUN && halt_i |=>
        vstate == VS_STOP)
        else $error("halt did not stop velocity mode");
    stop_done_a: assert property (s_stop_done ##1 ce_i |=>
        drive_status_word_o[`ST_END])
        else $error("mode end not reported at standstill");
    new_target_a: assert property (ce_i && vset_wr && vstate == VS_RUN &&
        new_clamped != speed |=> !drive_status_word_o[`ST_REACHED])
        else $error("reached bit not cleared on new setpoint");

endmodule
`default_nettype wire

// file: tb/bus_master_model.sv
// Purpose: fieldbus master stand-in issuing single parameter accesses
// Assumes: access taken on the edge where wr or rd is high, ack one cycle later
// Notes:   gap adds idle cycles before a request to act as a slow master
`timescale 1ns/1ps
`default_nettype none
module bus_master_model
    import drive_pkg::*;
(
    input  wire logic     clk_i, // system clock
    output var par_req_t  req_o, // access request
    input  wire par_rsp_t rsp_i  // access answer
);
    int gap;
    initial begin
        gap = 0;
        req_o = '0;
    end
    // whole signed words; setpoints go out whenever called, also before mode and state are set
    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                        output logic [31:0] rdat, output logic er, output logic ok);
        int n;
        ok = 1'b0;
        rdat = '0;
        er = 1'b1;
        repeat (gap) @(posedge clk_i);
        @(posedge clk_i);
        #1;
        req_o = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk_i);
        #1;
        // released lines show the inverse so a stale request cannot pass
        req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        for (n = 0; n < 4 && ok !== 1'b1; n++) begin
            if (rsp_i.ack === 1'b1) begin
                ok = 1'b1;
                rdat = rsp_i.rdata;
                er = rsp_i.err;
            end else begin
                @(posedge clk_i);
                #1;
            end
        end
    endtask
endmodule
`default_nettype wire

// file: tb/profile_param_top_test.sv
// Purpose: self-checking bench for the profile parameter block
// Assumes: every parameter access goes through bus_master_model
// Notes:   access table first, then velocity mode and reset by hand
`timescale 1ns/1ps
`default_nettype none
`include "drive_cfg.svh"
module profile_param_top_test
    import drive_pkg::*;
;
    typedef struct packed {
        logic        wr;
        logic [15:0] addr;
        logic [31:0] wdata;
        logic        err;
        logic [31:0] rdata;
    } row_t;
    logic        clk, nrst, vel_mode, op_en, halt, fault, homed, err, ok;
    logic        rel_o, abs_o, nvwr_o, nv_o, ce, nv_in;
    logic [31:0] limit, act_pos, gen_pos, rdata, tpos_o, pspd_o, vspd_o;
    logic [15:0] stat;
    par_req_t    req;
    par_rsp_t    rsp;
    int          failures, compares, nv_pulses;
    row_t        rows [19];

    bus_master_model bus_master_model_i (.clk_i(clk), .req_o(req), .rsp_i(rsp));
    profile_param_top profile_param_top_i (
        .clk_i(clk), .nrst_i(nrst), .ce_i(ce), .par_req_i(req), .par_rsp_o(rsp),
        .mode_velocity_i(vel_mode), .op_enabled_i(op_en), .halt_i(halt), .fault_i(fault),
        .homed_i(homed), .nv_home_i(nv_in), .maximum_speed_limit_i(limit),
        .acc_step_i(16'h000a), .dec_step_i(16'h0005), .actual_position_i(act_pos),
        .generator_position_i(gen_pos), .target_position_o(tpos_o),
        .position_speed_o(pspd_o), .relative_base_o(rel_o), .abs_allowed_o(abs_o),
        .nv_home_wr_o(nvwr_o), .nv_home_o(nv_o), .velocity_speed_o(vspd_o),
        .drive_status_word_o(stat));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (nvwr_o === 1'b1) begin
            nv_pulses++;
        end
    end

    task automatic chk(input logic c, input string m);
        compares++;
        if (c !== 1'b1) begin
            failures++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic end_sim;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
        bus_master_model_i.xfer(w, a, d, rdata, err, ok);
        if (ok !== 1'b1) begin
            chk(1'b0, "no answer");
            end_sim();
        end
    endtask
    // bounded wait for the generator speed; no step may exceed the accel step of 10
    task automatic reach(input logic [31:0] s);
        logic [31:0] prev;
        int i;
        for (i = 0; i < 100 && vspd_o !== s; i++) begin
            prev = vspd_o;
            cyc(1);
            chk($signed(vspd_o - prev) <= 10 && $signed(vspd_o - prev) >= -10, "ramp");
        end
        if (vspd_o !== s) begin
            chk(1'b0, "speed not reached");
            end_sim();
        end
    endtask

    initial begin
        failures = 0;
        compares = 0;
        nv_pulses = 0;
        nrst = 1'b0;
        {vel_mode, halt, fault, homed} = 4'h0;
        op_en = 1'b1;
        ce = 1'b1;
        nv_in = 1'b0;
        limit = 32'h0000_1000;
        act_pos = 32'h8000_1234;
        gen_pos = 32'hffff_fe00;
        rows = '{
            '{1'b0, `ADR_HOME_REQ, 32'h0, 1'b0, 32'h0},
            '{1'b0, `ADR_TRV_SPD, 32'h0, 1'b0, `RST_TRV_SPD},
            '{1'b0, `ADR_TGT_POS, 32'h0, 1'b0, 32'h0},
            '{1'b0, `ADR_ACT_POS, 32'h0, 1'b0, 32'h8000_1234},
            '{1'b0, `ADR_GEN_POS, 32'h0, 1'b0, 32'hffff_fe00},
            '{1'b1, `ADR_TGT_POS, 32'hffff_fff0, 1'b0, 32'h0},
            '{1'b0, `ADR_TGT_POS, 32'h0, 1'b0, 32'hffff_fff0},
            '{1'b1, `ADR_TRV_SPD, 32'h0, 1'b1, 32'h0},
            '{1'b1, `ADR_TRV_SPD, 32'h1, 1'b0, 32'h0},
            '{1'b0, `ADR_TRV_SPD, 32'h0, 1'b0, 32'h1},
            '{1'b1, `ADR_REL_OPT, 32'h1, 1'b1, 32'h0},
            '{1'b1, `ADR_REL_OPT, 32'h2, 1'b0, 32'h0},
            '{1'b1, `ADR_ACT_POS, 32'h5, 1'b1, 32'h0},
            '{1'b1, `ADR_GEN_POS, 32'h5, 1'b1, 32'h0},
            '{1'b1, `ADR_HOME_REQ, 32'h2, 1'b1, 32'h0},
            '{1'b1, `ADR_HOME_REQ, 32'h1, 1'b0, 32'h0},
            '{1'b0, `ADR_HOME_REQ, 32'h0, 1'b0, 32'h1},
            '{1'b0, 16'h0000, 32'h0, 1'b1, 32'h0},
            '{1'b0, `ADR_REL_OPT, 32'h0, 1'b0, 32'h2}};
        repeat (4) @(posedge clk);
        #1;
        nrst = 1'b1;
        foreach (rows[i]) begin
            acc(rows[i].wr, rows[i].addr, rows[i].wdata);
            chk(err === rows[i].err && rdata === rows[i].rdata, $sformatf("row %0d", i));
        end
        bus_master_model_i.gap = 2;
        chk(tpos_o === 32'hffff_fff0 && rel_o === 1'b1, "position outputs");
        chk(abs_o === 1'b0 && nv_o === 1'b1 && nv_pulses == 1, "homing gate");
        homed = 1'b1;
        cyc(2);
        chk(abs_o === 1'b1 && stat[`ST_REF_OK] === 1'b1, "homed");
        acc(1'b1, `ADR_TRV_SPD, 32'h0000_2000);
        cyc(1);
        chk(pspd_o === limit, "speed clamp");
        acc(1'b1, `ADR_VEL_SET, 32'd100);
        cyc(4);
        chk(vspd_o === 32'h0, "start refused");
        vel_mode = 1'b1;
        op_en = 1'b0;
        acc(1'b1, `ADR_VEL_SET, 32'd100);
        cyc(4);
        chk(vspd_o === 32'h0 && stat[`ST_END] === 1'b0, "start refused disabled");
        op_en = 1'b1;
        acc(1'b1, `ADR_VEL_SET, 32'd100);
        reach(32'd100);
        cyc(1);
        chk(stat[`ST_REACHED] === 1'b1 && stat[`ST_SPEED0] === 1'b0, "running");
        acc(1'b1, `ADR_VEL_SET, 32'd200);
        chk(stat[`ST_REACHED] === 1'b0, "reached kept");
        // enable low must freeze the ramp and the status word
        ce = 1'b0;
        cyc(3);
        chk(vspd_o === 32'd100 && stat[`ST_REACHED] === 1'b0, "frozen");
        ce = 1'b1;
        reach(32'd200);
        acc(1'b1, `ADR_VEL_SET, 32'hffff_ffce);
        reach(32'hffff_ffce);
        halt = 1'b1;
        reach(32'h0);
        cyc(3);
        chk(stat[`ST_END] === 1'b1 && stat[`ST_REACHED] === 1'b1, "halt stop");
        chk(stat[`ST_SPEED0] === 1'b1, "standstill");
        halt = 1'b0;
        acc(1'b1, `ADR_VEL_SET, 32'd30);
        reach(32'd30);
        acc(1'b1, `ADR_VEL_SET, 32'h0);
        reach(32'h0);
        cyc(3);
        chk(stat[`ST_END] === 1'b1 && stat[`ST_SPEED0] === 1'b1, "zero stop");
        acc(1'b1, `ADR_VEL_SET, 32'd40);
        reach(32'd40);
        fault = 1'b1;
        reach(32'h0);
        cyc(3);
        chk(stat[`ST_ERROR] === 1'b1 && stat[`ST_END] === 1'b1, "fault stop");
        // reset in mid-run must clear everything and restore defaults
        fault = 1'b0;
        acc(1'b1, `ADR_VEL_SET, 32'd50);
        cyc(2);
        nrst = 1'b0;
        cyc(1);
        chk(stat === 16'h0 && vspd_o === 32'h0 && pspd_o === 32'h0, "in reset");
        nv_in = 1'b1;
        nrst = 1'b1;
        acc(1'b0, `ADR_TRV_SPD, 32'h0);
        chk(rdata === `RST_TRV_SPD && pspd_o === `RST_TRV_SPD, "default speed");
        acc(1'b0, `ADR_HOME_REQ, 32'h0);
        chk(rdata === 32'h1 && nv_o === 1'b1, "stored setting restored");
        end_sim();
    end
endmodule
`default_nettype wire
